// [design/fwp_defs.vh]
`ifndef FWP_DEFS_VH
`define FWP_DEFS_VH
// ------------
// register offsets (byte addresses)
// ------------
`define FWP_OFF_SR1       8'h00
`define FWP_OFF_SR2       8'h04
`define FWP_OFF_SR3       8'h08
`define FWP_OFF_STAT      8'h0C
// ------------
// field positions
// ------------
`define FWP_SR1_LOCK      7
`define FWP_SR1_FINE      6
`define FWP_SR1_BOT       5
`define FWP_SR1_SIZE_HI   4
`define FWP_SR1_SIZE_LO   2
`define FWP_SR1_LATCH     1
`define FWP_SR1_BUSY      0
`define FWP_SR2_INV       6
`define FWP_SR2_QUAD      1
`define FWP_SR3_PRS       7
`define FWP_SR3_DRV_HI    6
`define FWP_SR3_DRV_LO    5
`define FWP_SR3_HFQ       4
`define FWP_ST_PUW_DONE   1
`define FWP_ST_SLEEP      2
`define FWP_ST_REFUSED    3
// ------------
// reset / factory values and write masks
// ------------
`define FWP_SR1_RST       8'h00
`define FWP_SR2_RST       8'h00
`define FWP_SR3_RST       8'h00
`define FWP_SR1_WMASK     8'hFC
`define FWP_SR2_WMASK     8'h42
`define FWP_SR3_WMASK     8'hF0
// ------------
// serial opcodes
// ------------
`define FWP_OP_UNLOCK     8'h06
`define FWP_OP_RELOCK     8'h04
`define FWP_OP_PAGE       8'h02
`define FWP_OP_W4K        8'h20
`define FWP_OP_W64K       8'hD8
`define FWP_OP_WALL       8'hC7
`define FWP_OP_WALL_ALT   8'h60
`define FWP_OP_SWR        8'h01
`define FWP_OP_SLEEP      8'hB9
`define FWP_OP_WAKE       8'hAB
// ------------
// operation kinds
// ------------
`define FWP_K_PAGE        3'h0
`define FWP_K_4K          3'h1
`define FWP_K_64K         3'h2
`define FWP_K_ALL         3'h3
`define FWP_K_SWR         3'h4
// ------------
// timing
// ------------
`define FWP_MCLK_MHZ      20
`define FWP_PUW_US        1000
`define FWP_PUW_CYC       (`FWP_PUW_US * `FWP_MCLK_MHZ)
`define FWP_OPT_US        5
`define FWP_OPT_CYC       (`FWP_OPT_US * `FWP_MCLK_MHZ)
`endif

// [design/fwp_sync.v]
`timescale 1ns/1ps
module fwp_sync #(
   parameter       W   = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input  wire         mclk,  // system clock
   input  wire         rst_b, // async reset, active low
   input  wire [W-1:0] d,     // asynchronous inputs
   output reg  [W-1:0] q      // synchronised outputs
);
   reg [W-1:0] meta_reg;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= RST;
         q        <= RST;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // fwp_sync

// [design/fwp_prot_map.v]
`timescale 1ns/1ps
`include "fwp_defs.vh"
module fwp_prot_map #(
   parameter [20:0] ARRAY_BYTES = 21'h100000
) (
   input  wire [2:0]  size,   // protect_size_field
   input  wire        fine,   // fine_granularity_sel
   input  wire        bottom, // bottom_origin_sel
   input  wire        invert, // invert_protect
   input  wire [2:0]  kind,   // operation kind
   input  wire [19:0] addr,   // target address
   output reg         hit     // target touches protected space
);
   reg [20:0] len;
   reg [20:0] lo;
   reg [20:0] hi;
   reg [20:0] tlo;
   reg [20:0] thi;
   reg        all_r;
   reg        none_r;
   reg        in_r;
   reg        ov_r;

   always @* begin
      len   = 21'h000000;
      all_r = 1'b0;
      if (fine) begin
         case (size)
            3'h1:    len = 21'h001000;
            3'h2:    len = 21'h002000;
            3'h3:    len = 21'h004000;
            3'h4,
            3'h5:    len = 21'h008000;
            3'h6,
            3'h7:    all_r = 1'b1;
            default: len = 21'h000000;
         endcase
      end else begin
         case (size)
            3'h1:    len = 21'h010000;
            3'h2:    len = 21'h020000;
            3'h3:    len = 21'h040000;
            3'h4:    len = 21'h080000;
            3'h5,
            3'h6,
            3'h7:    all_r = 1'b1;
            default: len = 21'h000000;
         endcase
      end
      none_r = ~all_r & (len == 21'h000000);
      if (bottom) begin
         lo = 21'h000000;
         hi = len - 21'h000001;
      end else begin
         lo = ARRAY_BYTES - len;
         hi = ARRAY_BYTES - 21'h000001;
      end
      case (kind)
         `FWP_K_PAGE: begin
            tlo = {1'b0, addr[19:8], 8'h00};
            thi = {1'b0, addr[19:8], 8'hFF};
         end
         `FWP_K_4K: begin
            tlo = {1'b0, addr[19:12], 12'h000};
            thi = {1'b0, addr[19:12], 12'hFFF};
         end
         `FWP_K_64K: begin
            tlo = {1'b0, addr[19:16], 16'h0000};
            thi = {1'b0, addr[19:16], 16'hFFFF};
         end
         default: begin
            tlo = 21'h000000;
            thi = ARRAY_BYTES - 21'h000001;
         end
      endcase
      ov_r = ~none_r & (all_r | ((tlo <= hi) & (thi >= lo)));
      in_r = all_r | (~none_r & (tlo >= lo) & (thi <= hi));
      hit  = invert ? ~in_r : ov_r;
   end
endmodule // fwp_prot_map

// [design/fwp_top.v]
// How it works
// - quad_io_enable is a stored bit at status_reg_two bit 1, default 0.
// - quad mode turns protect and pause/restart pins into data lines two and three.
// - pause_or_restart_select 0 gives pause pin, 1 gives restart pin.
// - pause_or_restart_select only matters while quad mode is off.
// - drive_strength_sel: 00=50%, 01=25%, 10=75%, 11=100%.
// - quad_fast_mode selects high-frequency mode; default 0.
// - write, program, erase need chip select rising on a byte boundary.
// - low supply holds the device in reset; no command recognised.
// - write-class commands refused until the power-up delay has run out.
// - write_latch_flag comes out of power-up cleared.
// - write-class commands refused unless write_latch_flag is set.
// - finishing program, erase or status write clears write_latch_flag.
// - in deep sleep only the wake command is obeyed.
// - status writes gated by protect pin together with status_lock_mode.
// - coarse map: top or bottom 1/16, 1/8, 1/4 or 1/2 of the array (64, 128, 256 or 512 kB).
// - fine map: 4, 8, 16 or 32 kB at top or bottom.
// - invert_protect protects the complement of the selected region.
// - program or erase touching any protected byte is ignored.
// - lock mode 0 ignores protect pin; mode 1 locks while pin low.
// - the unlock command sets write_latch_flag once the power-up delay has run out.
`timescale 1ns/1ps
`include "fwp_defs.vh"
module fwp_top #(
   parameter PUW_CYC = `FWP_PUW_CYC, // power-up write delay in mclk cycles
   parameter OPT_CYC = `FWP_OPT_CYC  // modelled busy time of an operation
) (
   input  wire        mclk,             // 20 MHz system clock
   input  wire        rst_b,            // async reset, active low
   input  wire        psel,             // apb select
   input  wire        penable,          // apb enable
   input  wire        pwrite,           // apb direction
   input  wire [7:0]  paddr,            // apb byte address
   input  wire [31:0] pwdata,           // apb write data
   output reg  [31:0] prdata,           // apb read data
   output reg         pready,           // apb ready
   output reg         pslverr,          // apb error on unmapped address
   input  wire        supply_low,       // supply below threshold, active high
   input  wire        cs_b,             // serial chip select, active low
   input  wire        sclk,             // serial clock
   input  wire        data_line_zero,   // serial data in
   input  wire        wp_pin_b,         // protect pin / data line two in
   input  wire        pr_pin_b,         // pause-restart pin / data line three in
   output reg         write_latch_flag, // write latch state
   output reg         busy,             // operation in progress
   output reg         deep_sleep_state, // deep sleep entered
   output reg         quad_io_enable,   // quad data lines active
   output reg         quad_fast_mode,   // quad high-frequency mode
   output reg  [1:0]  drive_strength_sel, // output drive code
   output reg         wp_function_on,   // protect pin acts as protect input
   output reg         pause_active,     // transfer paused by pause pin
   output reg         restart_active,   // restart pin asserted
   output reg         op_start,         // one-cycle pulse, operation accepted
   output reg  [2:0]  op_kind,          // kind of accepted operation
   output reg  [19:0] op_addr           // address of accepted operation
);
   // ------------
   // pin synchronisers
   // ------------
   wire [5:0] pins_s;
   wire       sel_s;
   wire       sclk_s;
   wire       si_s;
   wire       wp_s;
   wire       pr_s;
   wire       low_s;

   fwp_sync #(.W(6), .RST(6'h3C)) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     ({supply_low, pr_pin_b, wp_pin_b, data_line_zero, sclk, ~cs_b}),
      .q     (pins_s)
   );
   assign {low_s, pr_s, wp_s, si_s, sclk_s, sel_s} = pins_s;

   // ------------
   // configuration registers
   // ------------
   reg  [7:0]  sr1_reg;
   reg  [7:0]  sr2_reg;
   reg  [7:0]  sr3_reg;
   wire        quad  = sr2_reg[`FWP_SR2_QUAD];
   wire        lockm = sr1_reg[`FWP_SR1_LOCK];
   wire        prs   = sr3_reg[`FWP_SR3_PRS];

   // quad mode overrides both pin functions
   wire pause_now   = ~quad & ~prs & ~pr_s;
   wire restart_now = ~quad &  prs & ~pr_s;
   // with quad set the protect pin no longer locks anything
   wire sr_locked   = lockm & ~quad & ~wp_s;
   // supply drop or restart pin both act as a core reset
   wire core_rst    = low_s | restart_now;

   // ------------
   // serial frame capture
   // ------------
   reg         sclk_q_reg;
   reg         sel_q_reg;
   reg  [7:0]  sh_reg;
   reg  [2:0]  bit_cnt_reg;
   reg  [2:0]  byte_cnt_reg;
   reg  [7:0]  opc_reg;
   reg  [23:0] arg_reg;
   wire        sclk_rise = sclk_s & ~sclk_q_reg & sel_s & ~pause_now;
   wire        frame_beg = sel_s & ~sel_q_reg;
   wire        frame_end = ~sel_s & sel_q_reg;
   wire [7:0]  sh_next   = {sh_reg[6:0], si_s};

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_q_reg   <= 1'b0;
         sel_q_reg    <= 1'b0;
         sh_reg       <= 8'h00;
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= 3'h0;
         opc_reg      <= 8'h00;
         arg_reg      <= 24'h000000;
      end else begin
         sclk_q_reg <= sclk_s;
         sel_q_reg  <= sel_s;
         if (core_rst || frame_beg) begin
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= 3'h0;
         end else if (sclk_rise) begin
            sh_reg      <= sh_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
               if (byte_cnt_reg != 3'h7)
                  byte_cnt_reg <= byte_cnt_reg + 3'h1;
               if (byte_cnt_reg == 3'h0)
                  opc_reg <= sh_next;
               else if (byte_cnt_reg < 3'h4)
                  arg_reg[8*(3'h3 - byte_cnt_reg) +: 8] <= sh_next;
            end
         end
      end
   end

   // ------------
   // command acceptance
   // ------------
   wire        whole  = (bit_cnt_reg == 3'h0);
   reg  [2:0]  kind;
   reg         is_arr;
   reg         len_ok;
   wire        hit;

   fwp_prot_map u_map (
      .size   (sr1_reg[`FWP_SR1_SIZE_HI:`FWP_SR1_SIZE_LO]),
      .fine   (sr1_reg[`FWP_SR1_FINE]),
      .bottom (sr1_reg[`FWP_SR1_BOT]),
      .invert (sr2_reg[`FWP_SR2_INV]),
      .kind   (kind),
      .addr   (arg_reg[19:0]),
      .hit    (hit)
   );

   always @* begin
      kind   = `FWP_K_ALL;
      is_arr = 1'b0;
      len_ok = 1'b0;
      case (opc_reg)
         `FWP_OP_PAGE: begin
            kind   = `FWP_K_PAGE;
            is_arr = 1'b1;
            len_ok = (byte_cnt_reg > 3'h4);
         end
         `FWP_OP_W4K: begin
            kind   = `FWP_K_4K;
            is_arr = 1'b1;
            len_ok = (byte_cnt_reg == 3'h4);
         end
         `FWP_OP_W64K: begin
            kind   = `FWP_K_64K;
            is_arr = 1'b1;
            len_ok = (byte_cnt_reg == 3'h4);
         end
         `FWP_OP_WALL,
         `FWP_OP_WALL_ALT: begin
            is_arr = 1'b1;
            len_ok = (byte_cnt_reg == 3'h1);
         end
         `FWP_OP_SWR: begin
            kind   = `FWP_K_SWR;
            len_ok = (byte_cnt_reg > 3'h1);
         end
         default: len_ok = 1'b0;
      endcase
   end

   wire        have_op  = frame_end & (byte_cnt_reg != 3'h0) & ~core_rst;
   wire        may_cmd  = have_op & ~busy & ~deep_sleep_state;
   reg         puw_done_reg;
   wire        gate_ok  = whole & write_latch_flag & puw_done_reg;
   wire        arr_go   = may_cmd & is_arr & len_ok & gate_ok & ~hit;
   wire        swr_go   = may_cmd & (kind == `FWP_K_SWR) & len_ok & gate_ok & ~sr_locked;
   wire        go       = arr_go | swr_go;
   wire        write_cl = is_arr | (kind == `FWP_K_SWR);
   wire        refuse   = may_cmd & write_cl & ~go;
   // ------------
   // power-up delay and busy timer
   // ------------
   reg  [31:0] puw_cnt_reg;
   reg  [31:0] op_cnt_reg;
   reg         refused_reg;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         puw_cnt_reg  <= 32'h00000000;
         puw_done_reg <= 1'b0;
      end else if (low_s) begin
         puw_cnt_reg  <= 32'h00000000;
         puw_done_reg <= 1'b0;
      end else if (!puw_done_reg) begin
         puw_cnt_reg  <= puw_cnt_reg + 32'h00000001;
         puw_done_reg <= (puw_cnt_reg >= PUW_CYC - 1);
      end
   end

   // ------------
   // latch, busy, sleep and config update
   // ------------
   wire        ap_wr   = psel & penable & pready & pwrite;
   wire [7:0]  wb      = pwdata[7:0];

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         write_latch_flag <= 1'b0;
         busy             <= 1'b0;
         deep_sleep_state <= 1'b0;
         op_cnt_reg       <= 32'h00000000;
         op_start         <= 1'b0;
         op_kind          <= `FWP_K_ALL;
         op_addr          <= 20'h00000;
         refused_reg      <= 1'b0;
         sr1_reg          <= `FWP_SR1_RST;
         sr2_reg          <= `FWP_SR2_RST;
         sr3_reg          <= `FWP_SR3_RST;
      end else begin
         op_start <= go;
         if (core_rst) begin
            write_latch_flag <= 1'b0;
            busy             <= 1'b0;
            deep_sleep_state <= 1'b0;
         end else if (busy) begin
            op_cnt_reg <= op_cnt_reg - 32'h00000001;
            if (op_cnt_reg == 32'h00000001) begin
               busy             <= 1'b0;
               write_latch_flag <= 1'b0;
            end
         end else if (have_op && deep_sleep_state) begin
            if (opc_reg == `FWP_OP_WAKE)
               deep_sleep_state <= 1'b0;
         end else if (go) begin
            busy       <= 1'b1;
            op_cnt_reg <= OPT_CYC;
            op_kind    <= kind;
            op_addr    <= arg_reg[19:0];
            if (swr_go) begin
               sr1_reg <= (sr1_reg & ~`FWP_SR1_WMASK) | (arg_reg[23:16] & `FWP_SR1_WMASK);
               if (byte_cnt_reg > 3'h2)
                  sr2_reg <= (sr2_reg & ~`FWP_SR2_WMASK) | (arg_reg[15:8] & `FWP_SR2_WMASK);
               if (byte_cnt_reg > 3'h3)
                  sr3_reg <= (sr3_reg & ~`FWP_SR3_WMASK) | (arg_reg[7:0] & `FWP_SR3_WMASK);
            end
         end else if (may_cmd && whole) begin
            case (opc_reg)
               `FWP_OP_UNLOCK: if (puw_done_reg) write_latch_flag <= 1'b1;
               `FWP_OP_RELOCK: write_latch_flag <= 1'b0;
               `FWP_OP_SLEEP:  deep_sleep_state <= 1'b1;
               default:        deep_sleep_state <= deep_sleep_state;
            endcase
         end
         // back-door programming of the stored bits from software
         if (ap_wr && !go) begin
            case (paddr)
               `FWP_OFF_SR1: sr1_reg <= (sr1_reg & ~`FWP_SR1_WMASK) | (wb & `FWP_SR1_WMASK);
               `FWP_OFF_SR2: sr2_reg <= (sr2_reg & ~`FWP_SR2_WMASK) | (wb & `FWP_SR2_WMASK);
               `FWP_OFF_SR3: sr3_reg <= (sr3_reg & ~`FWP_SR3_WMASK) | (wb & `FWP_SR3_WMASK);
               default:      sr1_reg <= sr1_reg;
            endcase
         end
         // a new refusal wins over a clear in the same cycle
         if (refuse)
            refused_reg <= 1'b1;
         else if (ap_wr && paddr == `FWP_OFF_STAT && wb[`FWP_ST_REFUSED])
            refused_reg <= 1'b0;
      end
   end

   // ------------
   // registered pin-function outputs
   // ------------
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         quad_io_enable     <= 1'b0;
         quad_fast_mode     <= 1'b0;
         drive_strength_sel <= 2'h0;
         wp_function_on     <= 1'b1;
         pause_active       <= 1'b0;
         restart_active     <= 1'b0;
      end else begin
         quad_io_enable     <= quad;
         quad_fast_mode     <= sr3_reg[`FWP_SR3_HFQ];
         drive_strength_sel <= sr3_reg[`FWP_SR3_DRV_HI:`FWP_SR3_DRV_LO];
         wp_function_on     <= ~quad;
         pause_active       <= pause_now;
         restart_active     <= restart_now;
      end
   end

   // ------------
   // apb slave: one access cycle, no waits
   // ------------
   reg [31:0] rd_mux;
   reg        mapped;

   always @* begin
      mapped = 1'b1;
      case (paddr)
         `FWP_OFF_SR1:  rd_mux = {24'h000000, sr1_reg[7:2], write_latch_flag, busy};
         `FWP_OFF_SR2:  rd_mux = {24'h000000, sr2_reg};
         `FWP_OFF_SR3:  rd_mux = {24'h000000, sr3_reg};
         `FWP_OFF_STAT: rd_mux = {28'h0000000, refused_reg, deep_sleep_state,
                                  puw_done_reg, busy};
         default: begin
            rd_mux = 32'h00000000;
            mapped = 1'b0;
         end
      endcase
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel && !penable && !pwrite)
            prdata <= rd_mux;
      end
   end
endmodule // fwp_top

// [dv/fwp_monitor.sv]
`timescale 1ns/1ps
module fwp_monitor #(
   parameter PUW_CYC = 20000, // power-up write delay, mclk cycles
   parameter OPT_CYC = 100    // busy time of an operation
) (
   input wire mclk,             // system clock
   input wire rst_b,            // async reset, active low
   input wire supply_low,       // supply below threshold
   input wire write_latch_flag, // write latch
   input wire busy,             // operation in progress
   input wire deep_sleep_state, // deep sleep
   input wire quad_io_enable,   // quad lines on
   input wire wp_function_on,   // protect pin in use
   input wire pause_active,     // pause asserted
   input wire restart_active,   // restart asserted
   input wire op_start          // operation accepted
);
   localparam int BUSY_MAX = OPT_CYC + 2;
   int unsigned up_cnt;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // starts ahead of the design's own count
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         up_cnt <= 0;
      else if (supply_low)
         up_cnt <= 0;
      else if (up_cnt < PUW_CYC)
         up_cnt <= up_cnt + 1;
   end
   sequence s_busy_run;
      busy [*8] ##[1:BUSY_MAX] !busy;
   endsequence
   sequence s_latch_drop;
      ##[0:1] !write_latch_flag;
   endsequence
   property p_op_done;
      op_start |=> s_busy_run ##0 s_latch_drop;
   endproperty
   a_op_done: assert property (p_op_done) else $error("busy or latch wrong after op");
   property p_start_latch;
      op_start |-> write_latch_flag;
   endproperty
   a_start_latch: assert property (p_start_latch) else $error("op without latch");
   property p_sleep;
      deep_sleep_state |-> !op_start;
   endproperty
   a_sleep: assert property (p_sleep) else $error("op started in sleep");
   property p_latch_sleep;
      $rose(write_latch_flag) |-> !$past(deep_sleep_state);
   endproperty
   a_latch_sleep: assert property (p_latch_sleep) else $error("latch set in sleep");
   property p_supply;
      supply_low [*5] |-> !write_latch_flag && !busy && !deep_sleep_state;
   endproperty
   a_supply: assert property (p_supply) else $error("active under low supply");
   property p_powerup;
      $rose(write_latch_flag) |-> up_cnt >= PUW_CYC;
   endproperty
   a_powerup: assert property (p_powerup) else $error("latch set too early");
   property p_wp_func;
      quad_io_enable [*3] |-> !wp_function_on;
   endproperty
   a_wp_func: assert property (p_wp_func) else $error("protect pin live in quad");
   property p_pins_quad;
      quad_io_enable [*3] |-> !pause_active && !restart_active;
   endproperty
   a_pins_quad: assert property (p_pins_quad) else $error("pin function live in quad");
endmodule // fwp_monitor
bind fwp_top fwp_monitor #(.PUW_CYC(PUW_CYC), .OPT_CYC(OPT_CYC)) i_fwp_monitor (
   .mclk, .rst_b, .supply_low, .write_latch_flag, .busy, .deep_sleep_state, .quad_io_enable,
   .wp_function_on, .pause_active, .restart_active, .op_start);

// [dv/fwp_spi_host.sv]
`timescale 1ns/1ps
module fwp_spi_host (
   input  wire mclk, // system clock
   output reg  cs_b, // chip select, active low
   output reg  sclk, // serial clock, idles low
   output reg  sdo   // data to device
);
   initial begin
      cs_b = 1'b1;
      sclk = 1'b0;
      sdo  = 1'b0;
   end
   // n bits of d, msb first, 4 mclk per half period
   task automatic xfer(input logic [47:0] d, input int n);
      int i;
      @(posedge mclk);
      cs_b <= 1'b0;
      for (i = 0; i < n; i++) begin
         sdo <= d[47-i];
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         repeat (4) @(posedge mclk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      cs_b <= 1'b1;
      sdo  <= ~sdo; // released line shows the inverse
   endtask
endmodule // fwp_spi_host

// [dv/tb_fwp_top.sv]
`timescale 1ns/1ps
`include "fwp_defs.vh"
module tb_fwp_top;
   logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        supply_low = 1'b0, wp_pin_b = 1'b1, pr_pin_b = 1'b1, err, started;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, cs_b, sclk, sdo, write_latch_flag, busy, deep_sleep_state;
   logic        quad_io_enable, quad_fast_mode, wp_function_on, pause_active, restart_active;
   logic        op_start;
   logic [1:0]  drive_strength_sel;
   logic [2:0]  op_kind;
   logic [19:0] op_addr;
   logic [12:0] m_ok = 13'h05AA;
   logic [7:0]  m_sr1 [13] = '{8'h04, 8'h04, 8'h24, 8'h24, 8'h44, 8'h44, 8'h74, 8'h74, 8'h44,
                                8'h44, 8'h00, 8'h18, 8'h14};
   logic [19:0] m_adr [13] = '{20'hF0000, 20'hEF000, 20'h0F000, 20'h10000, 20'hFF000,
                                20'hFE000, 20'h07000, 20'h08000, 20'hFF000, 20'hFE000,
                                20'h00000, 20'h00000, 20'h00000};
   int          errors = 0, total_checks = 0;
   fwp_top #(.PUW_CYC(200), .OPT_CYC(10)) i_fwp_top (
      .mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .supply_low, .cs_b, .sclk, .data_line_zero(sdo), .wp_pin_b, .pr_pin_b, .write_latch_flag,
      .busy, .deep_sleep_state, .quad_io_enable, .quad_fast_mode, .drive_strength_sel,
      .wp_function_on, .pause_active, .restart_active, .op_start, .op_kind, .op_addr);
   fwp_spi_host i_fwp_spi_host (.mclk, .cs_b, .sclk, .sdo);
   initial begin
      forever #25 mclk = ~mclk;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bail;
      errors++;
      final_report;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) bail;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // op_start lasts one cycle: watch every edge
   task automatic send(input logic [47:0] d, input int n);
      int k;
      started = 1'b0;
      i_fwp_spi_host.xfer(d, n);
      for (k = 0; k < 12; k++) begin
         @(posedge mclk);
         if (op_start === 1'b1) started = 1'b1;
      end
      k = 0;
      while (busy !== 1'b0 && k < 40) begin
         @(posedge mclk);
         k++;
      end
      if (busy !== 1'b0) bail;
      @(posedge mclk);
   endtask
   task automatic unlock;
      send({`FWP_OP_UNLOCK, 40'h0}, 8);
   endtask
   task automatic erase(input logic [19:0] a);
      send({`FWP_OP_W4K, 4'h0, a, 16'h0}, 32);
   endtask
   task automatic wait_puw;
      int k;
      k = 0;
      rd = 32'h0;
      while (rd[`FWP_ST_PUW_DONE] !== 1'b1 && k < 200) begin
         apb(1'b0, `FWP_OFF_STAT, 32'h0);
         k++;
      end
      if (rd[`FWP_ST_PUW_DONE] !== 1'b1) bail;
   endtask
   task automatic t_power;
      chk(write_latch_flag, 0);
      unlock;
      chk(write_latch_flag, 0);
      wait_puw;
      unlock;
      chk(write_latch_flag, 1);
   endtask
   task automatic t_regs;
      apb(1'b0, 8'h10, 32'h0);
      chk({rd[30:0], err}, 1);
      apb(1'b0, `FWP_OFF_SR2, 32'h0);
      chk(rd, 32'h0);
      pr_pin_b <= 1'b0; // pins driven, never strapped, while quad is on
      apb(1'b1, `FWP_OFF_SR2, 32'h2);
      apb(1'b1, `FWP_OFF_SR3, 32'h80);
      apb(1'b0, `FWP_OFF_SR2, 32'h0);
      chk(rd, 32'h2);
      chk({quad_io_enable, wp_function_on, pause_active, restart_active}, 8);
      apb(1'b1, `FWP_OFF_SR2, 32'h0);
      repeat (4) @(posedge mclk);
      chk({wp_function_on, restart_active}, 3);
      apb(1'b1, `FWP_OFF_SR3, 32'h0);
      repeat (4) @(posedge mclk);
      chk({pause_active, restart_active}, 2);
      pr_pin_b <= 1'b1;
   endtask
   task automatic t_drive;
      int i;
      for (i = 0; i < 4; i++) begin
         apb(1'b1, `FWP_OFF_SR3, 32'h10 | (i << 5));
         repeat (3) @(posedge mclk);
         chk({quad_fast_mode, drive_strength_sel}, 4 + i);
      end
      apb(1'b1, `FWP_OFF_SR3, 32'h0);
      repeat (3) @(posedge mclk);
      chk(quad_fast_mode, 0);
   endtask
   task automatic t_frame;
      unlock;
      send({`FWP_OP_PAGE, 40'h0ABB000000}, 41);
      chk({started, write_latch_flag}, 1);
      erase(20'hABBCC);
      chk({started, write_latch_flag, op_kind, op_addr}, {2'b10, `FWP_K_4K, 20'hABBCC});
      erase(20'hABBCC);
      chk(started, 0);
   endtask
   task automatic t_map;
      int i;
      for (i = 0; i < 13; i++) begin
         apb(1'b1, `FWP_OFF_SR1, {24'h0, m_sr1[i]});
         apb(1'b1, `FWP_OFF_SR2, (i == 8 || i == 9) ? 32'h40 : 32'h0);
         unlock;
         erase(m_adr[i]);
         chk(started, m_ok[i]);
      end
      apb(1'b1, `FWP_OFF_SR1, 32'h0);
      apb(1'b1, `FWP_OFF_SR2, 32'h0);
   endtask
   task automatic t_lock;
      apb(1'b1, `FWP_OFF_SR1, 32'h80);
      wp_pin_b <= 1'b0;
      unlock;
      send({`FWP_OP_SWR, 8'h80, 32'h0}, 16);
      chk(started, 0);
      wp_pin_b <= 1'b1;
      send({`FWP_OP_SWR, 8'h80, 32'h0}, 16);
      chk({started, op_kind}, {1'b1, `FWP_K_SWR});
      apb(1'b1, `FWP_OFF_SR1, 32'h0);
      wp_pin_b <= 1'b0;
      unlock;
      send({`FWP_OP_SWR, 8'h00, 32'h0}, 16);
      chk(started, 1);
      wp_pin_b <= 1'b1;
   endtask
   task automatic t_sleep;
      send({`FWP_OP_SLEEP, 40'h0}, 8);
      unlock;
      chk({deep_sleep_state, write_latch_flag}, 2);
      send({`FWP_OP_WAKE, 40'h0}, 8);
      chk(deep_sleep_state, 0);
   endtask
   task automatic t_supply;
      unlock;
      supply_low <= 1'b1;
      unlock;
      chk(write_latch_flag, 0);
      supply_low <= 1'b0;
      wait_puw;
      unlock;
      chk(write_latch_flag, 1);
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      t_power;
      t_regs;
      t_drive;
      t_frame;
      t_map;
      t_lock;
      t_sleep;
      t_supply;
      final_report;
   end
endmodule // tb_fwp_top
